// >>> tb_voice_store_host_interface.sv
module tb_voice_store_host_interface import vsh_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SEG = 8;
    localparam int IDIV = 8;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic ext_on = 1'b0;
    logic ext_sample_clock = 1'b0;
    logic end_of_msg = 1'b0;
    logic mem_overflow = 1'b0;
    logic squelch_active = 1'b0;
    vsh_op_t op_kind = VSH_OP_IDLE;
    vsh_byte_t status_byte = 8'h00;
    wire spi_clk, spi_cs_n, spi_di, spi_do, spi_do_oe, cmd_valid, sample_tick, ext_clk_sel;
    wire seg_wrap, busy_n, segment_end_warn_n, attn_n_o, attn_n_oe, quiet_flag_n_o, quiet_flag_n_oe;
    wire vsh_byte_t cmd_byte;
    // Pulled-up open-drain wires
    wire attn_n_i = !(attn_n_oe && !attn_n_o);
    wire quiet_flag_n_i = !(quiet_flag_n_oe && !quiet_flag_n_o);
    integer seed = 32'h82a5_b279;
    int n_fail = 0;
    int comparisons = 0;
    int got = 0;
    int ticks = 0;
    int k;
    int g;
    vsh_byte_t exp_q[$];

    vsh_top #(.INT_DIV(IDIV), .EXT_LOSS_CYC(16), .EXT_DIV(1), .SEG_SAMPLES(SEG)) i_dut (
        .core_clk, .rst_n, .clk_en, .spi_clk, .spi_cs_n, .spi_di, .spi_do, .spi_do_oe,
        .ext_sample_clock, .op_kind, .status_byte, .end_of_msg, .mem_overflow,
        .squelch_active, .cmd_valid, .cmd_byte, .sample_tick, .ext_clk_sel, .seg_wrap,
        .busy_n, .segment_end_warn_n, .attn_n_i, .attn_n_o, .attn_n_oe, .quiet_flag_n_i,
        .quiet_flag_n_o, .quiet_flag_n_oe
    );
    vsh_host_model i_host (.spi_clk, .spi_cs_n, .spi_di, .spi_do, .spi_do_oe);

    always #12.5 core_clk = ~core_clk;
    always #150 ext_sample_clock = ext_on & ~ext_sample_clock;

    // ------------------------------------------------------------
    // Reference model: commands leave in arrival order
    // ------------------------------------------------------------
    always @(negedge core_clk)
    begin
        if (sample_tick === 1'b1)
            ticks++;
        if (cmd_valid === 1'b1)
        begin
            got++;
            if (exp_q.size() == 0)
                check(1'b0, "stray command");
            else
                check(cmd_byte === exp_q.pop_front(), "command byte");
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    task automatic check(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask

    task automatic conclude();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return sample_tick;
            1: return ext_clk_sel;
            2: return segment_end_warn_n;
            default: return seg_wrap;
        endcase
    endfunction

    task automatic await(input int s, input logic v, input int lim, input string m);
        for (k = 0; pick(s) !== v && k < lim; k++)
            cyc(1);
        if (pick(s) !== v)
        begin
            check(1'b0, m);
            conclude();
        end
    endtask

    task automatic gap(output int c);
        await(0, 1'b1, 40, "no sample tick");
        cyc(1);
        for (c = 1; sample_tick !== 1'b1 && c < 40; c++)
            cyc(1);
    endtask

    task automatic rst_chk();
        check({busy_n, segment_end_warn_n, attn_n_oe, quiet_flag_n_oe, cmd_valid, ext_clk_sel}
            === 6'b110000, "reset state");
    endtask

    task automatic send(input int nb, input int hp, input bit drain);
        vsh_byte_t tx[$];
        vsh_byte_t rx[$];
        for (int i = 0; i < nb; i++)
            tx.push_back(8'($random(seed)));
        // Select must be seen high before the reply word is taken
        cyc(3);
        status_byte = 8'($random(seed));
        cyc(1);
        foreach (tx[i])
            exp_q.push_back(tx[i]);
        i_host.hp = hp;
        i_host.frame(tx, rx);
        check(rx.size() == nb && i_host.oe_bad == 0, "reply length or drive");
        foreach (rx[i])
            check(rx[i] === status_byte, "reply byte");
        for (k = 0; drain && exp_q.size() > 0 && k < 12; k++)
            cyc(1);
        check(!drain || exp_q.size() == 0, "command not delivered");
    endtask

    initial
    begin
        #2_000_000;
        check(1'b0, "run too long");
        conclude();
    end

    initial
    begin
        cyc(16);
        rst_chk();
        rst_n = 1'b1;
        cyc(4);
        for (int f = 0; f < 6; f++)
            send(f % 3 + 1, f[0] ? 60 : 24, 1'b1);
        $display("test serial frames done");
        g = got;
        i_host.noise(12);
        cyc(8);
        check(got == g && spi_do_oe === 1'b0, "deselected activity taken");
        $display("test deselect done");
        for (int o = 0; o < 6; o++)
        begin
            op_kind = vsh_op_t'(o);
            cyc(2);
            check(busy_n === (o == 0), "busy level");
        end
        op_kind = VSH_OP_IDLE;
        $display("test busy done");
        for (int e = 0; e < 2; e++)
        begin
            {end_of_msg, mem_overflow} = e ? 2'b01 : 2'b10;
            cyc(1);
            {end_of_msg, mem_overflow} = 2'b00;
            cyc(1);
            check(attn_n_i === 1'b0, "attention not low");
            send(1, 24, 1'b1);
            check(attn_n_i === 1'b1, "attention not released");
        end
        clk_en = 1'b0;
        squelch_active = 1'b1;
        cyc(3);
        check(quiet_flag_n_i === 1'b1, "flag moved while frozen");
        clk_en = 1'b1;
        cyc(2);
        check(quiet_flag_n_i === 1'b0, "quiet flag not low");
        squelch_active = 1'b0;
        cyc(2);
        check(quiet_flag_n_i === 1'b1, "quiet flag stuck");
        $display("test flags done");
        // Start just after a tick so the tick count is not off by one
        await(0, 1'b1, 20, "no sample tick");
        cyc(1);
        op_kind = VSH_OP_RECORD;
        ticks = 0;
        g = got;
        send(1, 24, 1'b0);
        check(got == g && segment_end_warn_n === 1'b1, "command not held");
        await(2, 1'b0, 60, "warning never low");
        check(ticks == SEG / 2, "warning at wrong tick");
        cyc(2);
        check(got == g + 1, "held command not issued");
        await(3, 1'b1, 60, "no segment wrap");
        check(ticks == SEG && segment_end_warn_n === 1'b1, "wrap at wrong tick");
        await(2, 1'b0, 60, "second warning missing");
        send(1, 24, 1'b1);
        op_kind = VSH_OP_IDLE;
        cyc(2);
        check(segment_end_warn_n === 1'b1, "warning stuck after stop");
        $display("test segment done");
        ext_on = 1'b1;
        await(1, 1'b1, 60, "external clock not selected");
        gap(g);
        check(g >= 11 && g <= 13, "external tick spacing");
        ext_on = 1'b0;
        await(1, 1'b0, 40, "internal clock not restored");
        gap(g);
        check(g == IDIV, "internal tick spacing");
        $display("test sample clock done");
        op_kind = VSH_OP_PLAY;
        squelch_active = 1'b1;
        cyc(3);
        rst_n = 1'b0;
        cyc(2);
        rst_chk();
        rst_n = 1'b1;
        cyc(2);
        check(busy_n === 1'b0, "busy lost after reset");
        $display("test mid-run reset done");
        conclude();
    end
endmodule

// >>> vsh_cfg.svh
`ifndef VSH_CFG_SVH
`define VSH_CFG_SVH

// ------------------------------------------------------------
// Serial link framing
// ------------------------------------------------------------
`define VSH_BYTE_W 8
`define VSH_BIT_CNT_W 3
`define VSH_BIT_STEP 3'h1
`define VSH_LAST_BIT 3'h7
`define VSH_LOAD_BIT 3'h1
`define VSH_BIT_RST 3'h0
`define VSH_BYTE_RST 8'h00
`define VSH_SHIFT_RST 7'h00

// ------------------------------------------------------------
// Sample clock and segment timing
// ------------------------------------------------------------
`define VSH_CORE_HZ 40_000_000
`define VSH_CORE_NS 25
`define VSH_INT_RATE_HZ 6_400
`define VSH_EXT_LOSS_NS 100_000
`define VSH_EXT_DIV_DEF 1
`define VSH_SEG_SAMPLES_DEF 4096
`define VSH_CNT_W 16
`define VSH_CNT_RST 16'h0000
`define VSH_CNT_STEP 16'h0001

`endif

// >>> vsh_host_model.sv
module vsh_host_model import vsh_pkg::*; (
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_di,
    input wire logic spi_do,
    input wire logic spi_do_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    int hp = 24;
    bit oe_bad = 1'b0;

    initial
    begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_di = 1'b0;
    end

    // One extra clock at the end so the last reply bit can be sampled
    task automatic frame(input vsh_byte_t tx[$], output vsh_byte_t rx[$]);
        int n;
        vsh_byte_t r;
        n = tx.size() * 8;
        rx.delete();
        oe_bad = 1'b0;
        spi_cs_n = 1'b0;
        #100;
        for (int i = 0; i <= n; i++)
        begin
            if (i < n)
                spi_di = tx[i / 8][7 - i % 8];
            #(hp) spi_clk = 1'b1;
            if (i > 0)
            begin
                r = {r[6:0], spi_do};
                oe_bad |= (spi_do_oe !== 1'b1);
                if (i % 8 == 0)
                    rx.push_back(r);
            end
            #(hp) spi_clk = 1'b0;
        end
        spi_cs_n = 1'b1;
        spi_di = ~spi_di;
    endtask

    // Clocks with select high; the device must ignore all of it
    task automatic noise(input int n);
        repeat (n)
        begin
            spi_di = ~spi_di;
            #(hp) spi_clk = 1'b1;
            #(hp) spi_clk = 1'b0;
        end
    endtask
endmodule

// >>> vsh_link_if.sv
interface vsh_link_if import vsh_pkg::*; ();

    vsh_byte_t rx_byte;
    logic rx_tgl;
    vsh_byte_t tx_word;

    modport link (output rx_byte, output rx_tgl, input tx_word);
    modport core (input rx_byte, input rx_tgl, output tx_word);

endinterface

// >>> vsh_pkg.sv
`include "vsh_cfg.svh"

package vsh_pkg;

    // ------------------------------------------------------------
    // Shared types
    // ------------------------------------------------------------
    typedef logic [`VSH_BYTE_W-1:0] vsh_byte_t;
    typedef logic [`VSH_CNT_W-1:0] vsh_cnt_t;

    typedef enum logic [2:0] {
        VSH_OP_IDLE = 3'h0,
        VSH_OP_RECORD = 3'h1,
        VSH_OP_PLAY = 3'h2,
        VSH_OP_DIG_WR = 3'h3,
        VSH_OP_DIG_RD = 3'h4,
        VSH_OP_FWD = 3'h5
    } vsh_op_t;

    typedef enum logic [1:0] {
        VSH_SEG_IDLE = 2'h0,
        VSH_SEG_FIRST = 2'h1,
        VSH_SEG_SECOND = 2'h3
    } vsh_seg_t;

endpackage

// >>> vsh_spi_link.sv
`include "vsh_cfg.svh"

module vsh_spi_link import vsh_pkg::*; (
    input wire logic spi_clk,
    input wire logic frame_rst_n,
    input wire logic rst_n,
    input wire logic spi_di,
    vsh_link_if.link lnk,
    output logic spi_do,
    output logic spi_do_oe
);

    logic [`VSH_BIT_CNT_W-1:0] bit_cnt_ff;
    logic [`VSH_BYTE_W-2:0] rx_sh_ff;
    vsh_byte_t rx_byte_ff;
    logic rx_tgl_ff;
    vsh_byte_t tx_sh_ff;
    logic do_ff;
    logic do_oe_ff;

    // ------------------------------------------------------------
    // Receive on rising edge
    // ------------------------------------------------------------
    // Held in reset while deselected, so stray edges are dropped
    always_ff @(posedge spi_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            bit_cnt_ff <= `VSH_BIT_RST;
            rx_sh_ff <= `VSH_SHIFT_RST;
        end
        else
        begin
            bit_cnt_ff <= bit_cnt_ff + `VSH_BIT_STEP;
            rx_sh_ff <= {rx_sh_ff[`VSH_BYTE_W-3:0], spi_di};
        end
    end

    // Byte stays put for eight link edges, long enough for the core to sample
    always_ff @(posedge spi_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_byte_ff <= `VSH_BYTE_RST;
            rx_tgl_ff <= 1'b0;
        end
        else if (bit_cnt_ff == `VSH_LAST_BIT)
        begin
            rx_byte_ff <= {rx_sh_ff, spi_di};
            rx_tgl_ff <= ~rx_tgl_ff;
        end
    end

    // ------------------------------------------------------------
    // Transmit on falling edge
    // ------------------------------------------------------------
    // The first bit can only leave after a falling edge, so replies lag one clock
    always_ff @(negedge spi_clk or negedge frame_rst_n)
    begin
        if (!frame_rst_n)
        begin
            do_oe_ff <= 1'b0;
            do_ff <= 1'b0;
            tx_sh_ff <= `VSH_BYTE_RST;
        end
        else
        begin
            do_oe_ff <= 1'b1;
            if (bit_cnt_ff == `VSH_LOAD_BIT)
            begin
                do_ff <= lnk.tx_word[`VSH_BYTE_W-1];
                tx_sh_ff <= {lnk.tx_word[`VSH_BYTE_W-2:0], 1'b0};
            end
            else
            begin
                do_ff <= tx_sh_ff[`VSH_BYTE_W-1];
                tx_sh_ff <= {tx_sh_ff[`VSH_BYTE_W-2:0], 1'b0};
            end
        end
    end

    assign lnk.rx_byte = rx_byte_ff;
    assign lnk.rx_tgl = rx_tgl_ff;
    assign spi_do = do_ff;
    assign spi_do_oe = do_oe_ff;

endmodule

// >>> vsh_top.sv
`include "vsh_cfg.svh"

module vsh_top import vsh_pkg::*; #(
    parameter int unsigned INT_DIV = `VSH_CORE_HZ / `VSH_INT_RATE_HZ,
    parameter int unsigned EXT_LOSS_CYC = `VSH_EXT_LOSS_NS / `VSH_CORE_NS,
    parameter int unsigned EXT_DIV = `VSH_EXT_DIV_DEF,
    parameter int unsigned SEG_SAMPLES = `VSH_SEG_SAMPLES_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_di,
    output logic spi_do,
    output logic spi_do_oe,
    input wire logic ext_sample_clock,
    input wire vsh_op_t op_kind,
    input wire vsh_byte_t status_byte,
    input wire logic end_of_msg,
    input wire logic mem_overflow,
    input wire logic squelch_active,
    output logic cmd_valid,
    output vsh_byte_t cmd_byte,
    output logic sample_tick,
    output logic ext_clk_sel,
    output logic seg_wrap,
    output logic busy_n,
    output logic segment_end_warn_n,
    input wire logic attn_n_i,
    output logic attn_n_o,
    output logic attn_n_oe,
    input wire logic quiet_flag_n_i,
    output logic quiet_flag_n_o,
    output logic quiet_flag_n_oe
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic vsh_cnt_t cnt_last(input int unsigned n);
        cnt_last = vsh_cnt_t'(n - 1);
    endfunction

    function automatic logic seg_op(input vsh_op_t op);
        seg_op = (op == VSH_OP_RECORD) || (op == VSH_OP_PLAY) || (op == VSH_OP_FWD);
    endfunction

    vsh_link_if lnk ();

    logic frame_rst_n;
    logic cs_meta_ff;
    logic cs_sync_ff;
    logic tgl_meta_ff;
    logic tgl_sync_ff;
    logic tgl_seen_ff;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_prev_ff;
    vsh_byte_t tx_word_ff;
    vsh_byte_t rx_data_ff;
    logic rx_new_ff;
    vsh_cnt_t loss_cnt_ff;
    logic ext_sel_ff;
    vsh_cnt_t int_cnt_ff;
    vsh_cnt_t ext_cnt_ff;
    logic tick_ff;
    vsh_seg_t seg_state_ff;
    vsh_cnt_t seg_cnt_ff;
    logic warn_n_ff;
    logic wrap_ff;
    logic pend_ff;
    vsh_byte_t pend_byte_ff;
    logic cmd_valid_ff;
    vsh_byte_t cmd_byte_ff;
    logic busy_n_ff;
    logic attn_oe_ff;
    logic quiet_oe_ff;
    logic ext_rise;
    logic seg_active;
    logic accept_now;

    // ------------------------------------------------------------
    // Serial link, on the link clock
    // ------------------------------------------------------------
    // Deselect holds the frame logic in reset; it is gated by the system reset too
    assign frame_rst_n = rst_n & ~spi_cs_n;

    vsh_spi_link u_link (
        .spi_clk(spi_clk),
        .frame_rst_n(frame_rst_n),
        .rst_n(rst_n),
        .spi_di(spi_di),
        .lnk(lnk.link),
        .spi_do(spi_do),
        .spi_do_oe(spi_do_oe)
    );

    // ------------------------------------------------------------
    // Crossings into the core clock
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            tgl_meta_ff <= 1'b0;
            tgl_sync_ff <= 1'b0;
            tgl_seen_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            cs_meta_ff <= spi_cs_n;
            cs_sync_ff <= cs_meta_ff;
            tgl_meta_ff <= lnk.rx_tgl;
            tgl_sync_ff <= tgl_meta_ff;
            tgl_seen_ff <= tgl_sync_ff;
        end
    end

    // Reply word changes only while the synced select is high, up to two core clocks after select falls
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_word_ff <= `VSH_BYTE_RST;
        end
        else if (clk_en && cs_sync_ff)
        begin
            tx_word_ff <= status_byte;
        end
    end

    assign lnk.tx_word = tx_word_ff;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_data_ff <= `VSH_BYTE_RST;
            rx_new_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            rx_new_ff <= tgl_sync_ff ^ tgl_seen_ff;
            if (tgl_sync_ff ^ tgl_seen_ff)
            begin
                rx_data_ff <= lnk.rx_byte;
            end
        end
    end

    // ------------------------------------------------------------
    // Sample clock source
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            ext_meta_ff <= ext_sample_clock;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
        end
    end

    assign ext_rise = ext_sync_ff & ~ext_prev_ff;

    // Presence is judged by edges; a clock slower than the loss window is missed
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            loss_cnt_ff <= `VSH_CNT_RST;
            ext_sel_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (ext_rise)
            begin
                loss_cnt_ff <= `VSH_CNT_RST;
                ext_sel_ff <= 1'b1;
            end
            else if (loss_cnt_ff == cnt_last(EXT_LOSS_CYC))
            begin
                ext_sel_ff <= 1'b0;
            end
            else
            begin
                loss_cnt_ff <= loss_cnt_ff + `VSH_CNT_STEP;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            int_cnt_ff <= `VSH_CNT_RST;
            ext_cnt_ff <= `VSH_CNT_RST;
            tick_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            tick_ff <= 1'b0;
            if (int_cnt_ff == cnt_last(INT_DIV))
            begin
                int_cnt_ff <= `VSH_CNT_RST;
                tick_ff <= ~ext_sel_ff;
            end
            else
            begin
                int_cnt_ff <= int_cnt_ff + `VSH_CNT_STEP;
            end
            if (ext_rise)
            begin
                if (ext_cnt_ff == cnt_last(EXT_DIV))
                begin
                    ext_cnt_ff <= `VSH_CNT_RST;
                    tick_ff <= ext_sel_ff || int_cnt_ff == cnt_last(INT_DIV);
                end
                else
                begin
                    ext_cnt_ff <= ext_cnt_ff + `VSH_CNT_STEP;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Segment tracking and warning
    // ------------------------------------------------------------
    assign seg_active = seg_op(op_kind);

    // Segment position is the address state that reset clears
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            seg_state_ff <= VSH_SEG_IDLE;
            seg_cnt_ff <= `VSH_CNT_RST;
            warn_n_ff <= 1'b1;
            wrap_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            wrap_ff <= 1'b0;
            if (!seg_active)
            begin
                seg_state_ff <= VSH_SEG_IDLE;
                seg_cnt_ff <= `VSH_CNT_RST;
                warn_n_ff <= 1'b1;
            end
            else
            begin
                case (seg_state_ff)
                    VSH_SEG_IDLE:
                    begin
                        seg_state_ff <= VSH_SEG_FIRST;
                        seg_cnt_ff <= `VSH_CNT_RST;
                    end
                    VSH_SEG_FIRST:
                    begin
                        if (tick_ff)
                        begin
                            seg_cnt_ff <= seg_cnt_ff + `VSH_CNT_STEP;
                            if (seg_cnt_ff == cnt_last(SEG_SAMPLES / 2))
                            begin
                                seg_state_ff <= VSH_SEG_SECOND;
                                warn_n_ff <= 1'b0;
                            end
                        end
                    end
                    VSH_SEG_SECOND:
                    begin
                        if (tick_ff)
                        begin
                            if (seg_cnt_ff == cnt_last(SEG_SAMPLES))
                            begin
                                seg_cnt_ff <= `VSH_CNT_RST;
                                seg_state_ff <= VSH_SEG_FIRST;
                                warn_n_ff <= 1'b1;
                                wrap_ff <= 1'b1;
                            end
                            else
                            begin
                                seg_cnt_ff <= seg_cnt_ff + `VSH_CNT_STEP;
                            end
                        end
                    end
                    default:
                    begin
                        seg_state_ff <= VSH_SEG_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------
    // One slot only: a second late command replaces the first
    assign accept_now = ~seg_active | ~warn_n_ff;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_ff <= 1'b0;
            pend_byte_ff <= `VSH_BYTE_RST;
            cmd_valid_ff <= 1'b0;
            cmd_byte_ff <= `VSH_BYTE_RST;
        end
        else if (clk_en)
        begin
            cmd_valid_ff <= 1'b0;
            if (pend_ff && accept_now)
            begin
                cmd_valid_ff <= 1'b1;
                cmd_byte_ff <= pend_byte_ff;
                pend_ff <= rx_new_ff;
                pend_byte_ff <= rx_data_ff;
            end
            else if (rx_new_ff)
            begin
                if (accept_now)
                begin
                    cmd_valid_ff <= 1'b1;
                    cmd_byte_ff <= rx_data_ff;
                end
                else
                begin
                    pend_ff <= 1'b1;
                    pend_byte_ff <= rx_data_ff;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Handshake outputs
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            busy_n_ff <= 1'b1;
            quiet_oe_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            busy_n_ff <= (op_kind == VSH_OP_IDLE);
            quiet_oe_ff <= squelch_active;
        end
    end

    // Attention stays asserted until the host sends any byte; a new event wins
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            attn_oe_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (end_of_msg || mem_overflow)
            begin
                attn_oe_ff <= 1'b1;
            end
            else if (rx_new_ff)
            begin
                attn_oe_ff <= 1'b0;
            end
        end
    end

    assign cmd_valid = cmd_valid_ff;
    assign cmd_byte = cmd_byte_ff;
    assign sample_tick = tick_ff;
    assign ext_clk_sel = ext_sel_ff;
    assign seg_wrap = wrap_ff;
    assign busy_n = busy_n_ff;
    assign segment_end_warn_n = warn_n_ff;
    assign attn_n_oe = attn_oe_ff;
    assign quiet_flag_n_oe = quiet_oe_ff;
    // Open-drain pins only ever pull low; the pin levels are not read back
    assign attn_n_o = 1'b0;
    assign quiet_flag_n_o = 1'b0;

endmodule

// >>> vsh_top_asserts.sv
module vsh_top_asserts import vsh_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic spi_cs_n,
    input wire logic spi_do_oe,
    input wire vsh_op_t op_kind,
    input wire logic end_of_msg,
    input wire logic mem_overflow,
    input wire logic squelch_active,
    input wire logic cmd_valid,
    input wire vsh_byte_t cmd_byte,
    input wire logic seg_wrap,
    input wire logic busy_n,
    input wire logic segment_end_warn_n,
    input wire logic attn_n_o,
    input wire logic attn_n_oe,
    input wire logic quiet_flag_n_o,
    input wire logic quiet_flag_n_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Core domain checks
    // ------------------------------------------------------------
    wire seg_op = op_kind inside {VSH_OP_RECORD, VSH_OP_PLAY, VSH_OP_FWD};

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_event;
        clk_en && (end_of_msg || mem_overflow);
    endsequence

    sequence s_pull_low;
        attn_n_oe && !attn_n_o;
    endsequence

    chk_attn_event: assert property (s_event |=> s_pull_low)
        else $error("attention not pulled after event");
    chk_open_drain: assert property (!(attn_n_oe && attn_n_o) && !(quiet_flag_n_oe && quiet_flag_n_o))
        else $error("open-drain pin driven high");
    chk_quiet_follow: assert property (clk_en |=> quiet_flag_n_oe == $past(squelch_active))
        else $error("quiet flag does not follow squelch");
    chk_busy_low: assert property (clk_en && op_kind != VSH_OP_IDLE |=> !busy_n)
        else $error("busy not low during operation");
    chk_busy_high: assert property (clk_en && op_kind == VSH_OP_IDLE |=> busy_n)
        else $error("busy low while idle");
    chk_do_float: assert property (spi_cs_n |-> !spi_do_oe)
        else $error("data out driven while deselected");
    chk_warn_idle: assert property (clk_en && op_kind == VSH_OP_IDLE |=> segment_end_warn_n)
        else $error("warning low while idle");
    chk_wrap_release: assert property (seg_wrap |-> $rose(segment_end_warn_n))
        else $error("segment wrap without warning release");
    chk_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
        else $error("command strobe longer than one cycle");
    chk_cmd_hold: assert property (!cmd_valid |-> $stable(cmd_byte))
        else $error("command byte changed without strobe");
    // A byte held back during a segment may only leave while the warning is low
    chk_queue_hold: assert property (cmd_valid && $past(seg_op) && $past(seg_op, 2) |-> !segment_end_warn_n)
        else $error("command issued outside warning window");
endmodule

bind vsh_top vsh_top_asserts i_chk (
    .core_clk, .rst_n, .clk_en, .spi_cs_n, .spi_do_oe, .op_kind, .end_of_msg, .mem_overflow,
    .squelch_active, .cmd_valid, .cmd_byte, .seg_wrap, .busy_n, .segment_end_warn_n,
    .attn_n_o, .attn_n_oe, .quiet_flag_n_o, .quiet_flag_n_oe
);
